/* File: supply_diag_pkg.sv */
// constants, field layout and carrier types for the supply diagnostic status bank
// shared by the status bank, its host model, its assertions and its test bench
package supply_diag_pkg;

  // register map, one byte per register
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] PROTECTION_STATUS_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] TONE_CURRENT_STATUS_ADDR = 8'h01;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  // protection_status fields
  localparam int unsigned OVERLOAD_BIT = 0;
  localparam int unsigned OUTPUT_VOLTAGE_LOW_BIT = 2;
  localparam int unsigned PULLDOWN_OVERCURRENT_BIT = 4;
  localparam int unsigned OVERTEMP_BIT = 6;
  localparam int unsigned LOW_SUPPLY_BIT = 7;

  // tone_current_status fields
  localparam int unsigned TONE_PRESENT_BIT = 0;
  localparam int unsigned TONE_QUALITY_BIT = 2;
  localparam int unsigned LOW_LOAD_CURRENT_BIT = 4;

  // junction temperature thresholds in degrees C
  localparam int unsigned TEMP_W = 8;
  localparam logic [TEMP_W-1:0] OVERTEMP_SET_C = 8'h96;
  localparam logic [TEMP_W-1:0] OVERTEMP_CLEAR_C = 8'h87;

  // timing
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned DEGLITCH_TIME_NS = 1000;
  localparam int unsigned DEGLITCH_CYCLES =
    (DEGLITCH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // live condition inputs from the analog comparators
  typedef struct packed {
    logic overload;
    logic output_voltage_low;
    logic pulldown_overcurrent;
    logic low_power_diagnostic;
    logic tone_detector_input;
    logic tone_out_of_limits;
    logic load_current_low;
  } diag_cond_type;

  // register read port request
  typedef struct packed {
    logic rd_req;
    logic wr_req;
    logic [ADDR_W-1:0] addr;
  } reg_req_type;

  // register read port answer
  typedef struct packed {
    logic valid;
    logic write_refused;
    logic unmapped;
    logic [DATA_W-1:0] data;
  } reg_rsp_type;

endpackage : supply_diag_pkg

/* File: pulldown_deglitch.sv */
// persistence filter: output rises once the input has stood high for a full period
// input is synchronous to clk_sys; output is registered
`timescale 1ns/1ps
module pulldown_deglitch #(
  parameter int unsigned CYCLES = 250
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // filter
  input wire logic raw,
  output logic filtered
);
  localparam int unsigned CNT_W = $clog2(CYCLES + 1);

  logic [CNT_W-1:0] count_q;
  logic filtered_q;

  initial begin
    if (CYCLES < 1) begin
      $error("pulldown_deglitch: CYCLES must be at least 1");
    end
  end

  // count consecutive high cycles, restart on any low
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !raw) begin
      count_q <= '0;
    end else if (count_q != CNT_W'(CYCLES)) begin
      count_q <= count_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      filtered_q <= 1'b0;
    end else begin
      filtered_q <= raw && (count_q == CNT_W'(CYCLES));
    end
  end

  assign filtered = filtered_q;

endmodule : pulldown_deglitch

/* File: supply_diag_status_regs.sv */
// read-only diagnostic status bank: protection_status and tone_current_status
// assumes a serial host slave in front issuing one-cycle read/write requests
//
// Behaviour
// RULE1: protection_status answers reads at address 0x0 as a read-only byte.
// RULE2: tone_current_status answers reads at address 0x1 as a read-only byte.
// RULE3: all status bits are zero after reset.
// RULE4: pull-down overcurrent bit 4 reads 0 when no overcurrent exists.
// RULE5: overtemperature bit 6 sets when junction temperature exceeds 150 C.
// RULE6: overtemperature bit clears below 135 C, holding in between.
// RULE7: low supply bit 7 follows the supply comparator.
// RULE8: tone present bit 0 follows tone detection on the detector input.
// RULE9: tone quality bit 2 reads 1 when detected tone is out of limits.
// RULE10: tone quality bit reads 0 when tone is within limits.
// RULE11: low load current bit 4 reads 1 while current is under threshold.
// RULE12: low load current bit reads 0 while current is above threshold.
// RULE13: both registers are read only; writes are refused.
// RULE14: overload bit 0 follows the output overload protection.
// RULE15: pull-down bit sets after overcurrent outlasts the deglitch period.
// RULE16: reserved bits read zero; flags track live inputs without latching.
`timescale 1ns/1ps
module supply_diag_status_regs
  import supply_diag_pkg::*;
#(
  parameter int unsigned DEGLITCH = supply_diag_pkg::DEGLITCH_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // live diagnostic conditions
  input wire supply_diag_pkg::diag_cond_type cond,
  input wire logic [supply_diag_pkg::TEMP_W-1:0] junction_temp_c,
  // register port from the serial host slave
  input wire supply_diag_pkg::reg_req_type req,
  output supply_diag_pkg::reg_rsp_type rsp,
  // status mirrors
  output logic [supply_diag_pkg::DATA_W-1:0] protection_status,
  output logic [supply_diag_pkg::DATA_W-1:0] tone_current_status
);
  import supply_diag_pkg::*;

  initial begin
    if (DEGLITCH < 1) begin
      $error("supply_diag_status_regs: DEGLITCH must be at least 1");
    end
  end

  typedef enum logic [1:0] {
    SEL_PROTECTION = 2'b01,
    SEL_TONE_CURRENT = 2'b10
  } reg_sel_type;

  // one-hot register select, zero when unmapped
  function automatic logic [1:0] decode_addr(input logic [ADDR_W-1:0] a);
    logic [1:0] sel;
    sel = 2'b00;
    if (a == PROTECTION_STATUS_ADDR) begin
      sel = SEL_PROTECTION;
    end else if (a == TONE_CURRENT_STATUS_ADDR) begin
      sel = SEL_TONE_CURRENT;
    end
    return sel;
  endfunction : decode_addr

  logic pulldown_filtered;
  logic overtemp_flag_q;
  logic [DATA_W-1:0] protection_status_q;
  logic [DATA_W-1:0] protection_status_d;
  logic [DATA_W-1:0] tone_current_status_q;
  logic [DATA_W-1:0] tone_current_status_d;
  reg_rsp_type rsp_q;
  reg_rsp_type rsp_d;
  logic [1:0] rd_sel;

  // pull-down stage overcurrent must persist before it is reported
  pulldown_deglitch #(
    .CYCLES(DEGLITCH)
  ) u_pulldown_deglitch (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .raw(cond.pulldown_overcurrent),
    .filtered(pulldown_filtered)
  );

  // overtemperature with hysteresis band
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      overtemp_flag_q <= 1'b0; // RULE3
    end else if (junction_temp_c > OVERTEMP_SET_C) begin
      overtemp_flag_q <= 1'b1; // RULE5
    end else if (junction_temp_c < OVERTEMP_CLEAR_C) begin
      overtemp_flag_q <= 1'b0; // RULE6
    end
  end

  // protection_status image, reserved bits zero
  always_comb begin
    protection_status_d = STATUS_RESET; // RULE16
    protection_status_d[OVERLOAD_BIT] = cond.overload; // RULE14
    protection_status_d[OUTPUT_VOLTAGE_LOW_BIT] = cond.output_voltage_low;
    protection_status_d[PULLDOWN_OVERCURRENT_BIT] = pulldown_filtered; // RULE4 RULE15
    protection_status_d[OVERTEMP_BIT] = overtemp_flag_q; // RULE5
    protection_status_d[LOW_SUPPLY_BIT] = cond.low_power_diagnostic; // RULE7
  end

  // tone_current_status image, reserved bits zero
  always_comb begin
    tone_current_status_d = STATUS_RESET; // RULE16
    tone_current_status_d[TONE_PRESENT_BIT] = cond.tone_detector_input; // RULE8
    // quality only judged on a tone that is present
    tone_current_status_d[TONE_QUALITY_BIT] =
      cond.tone_detector_input && cond.tone_out_of_limits; // RULE9 RULE10
    tone_current_status_d[LOW_LOAD_CURRENT_BIT] = cond.load_current_low; // RULE11 RULE12
  end

  // flags refresh every cycle, never latched
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      protection_status_q <= STATUS_RESET; // RULE3
      tone_current_status_q <= STATUS_RESET; // RULE3
    end else begin
      protection_status_q <= protection_status_d; // RULE16
      tone_current_status_q <= tone_current_status_d; // RULE16
    end
  end

  assign rd_sel = decode_addr(req.addr);

  // answer for the request seen this cycle
  always_comb begin
    rsp_d = '0;
    if (req.wr_req) begin
      rsp_d.valid = 1'b1;
      rsp_d.write_refused = 1'b1; // RULE13
      rsp_d.unmapped = (decode_addr(req.addr) == 2'b00);
      rsp_d.data = UNMAPPED_READ;
    end else if (req.rd_req) begin
      rsp_d.valid = 1'b1;
      case (rd_sel)
        SEL_PROTECTION: begin
          rsp_d.data = protection_status_q; // RULE1
        end
        SEL_TONE_CURRENT: begin
          rsp_d.data = tone_current_status_q; // RULE2
        end
        default: begin
          rsp_d.unmapped = 1'b1;
          rsp_d.data = UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign rsp = rsp_q;
  assign protection_status = protection_status_q;
  assign tone_current_status = tone_current_status_q;

endmodule : supply_diag_status_regs

/* File: host_ctrl.sv */
// host reader model: one register request per call
// assumes clk_sys from the bench
`timescale 1ns/1ps
module host_ctrl (
  // clock
  input wire logic clk_sys,
  // request port
  output supply_diag_pkg::reg_req_type req
);
  import supply_diag_pkg::*;
  initial req = '0;
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    req <= '{rd_req: !wr, wr_req: wr, addr: a};
    @(posedge clk_sys);
    req <= '0;
  endtask : access
endmodule : host_ctrl

/* File: supply_diag_status_regs_assertions.sv */
// port checks for the status bank
// bound to every supply_diag_status_regs instance
`timescale 1ns/1ps
module supply_diag_status_regs_assertions #(
  parameter int unsigned DEGLITCH = supply_diag_pkg::DEGLITCH_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // watched ports
  input wire supply_diag_pkg::diag_cond_type cond,
  input wire logic [7:0] junction_temp_c,
  input wire supply_diag_pkg::reg_req_type req,
  input wire supply_diag_pkg::reg_rsp_type rsp,
  input wire logic [7:0] protection_status,
  input wire logic [7:0] tone_current_status
);
  import supply_diag_pkg::*;
  localparam int unsigned RUN_W = $clog2(DEGLITCH + 1);
  // consecutive cycles of pull-down overcurrent seen, saturating
  logic [RUN_W-1:0] run_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !cond.pulldown_overcurrent) begin
      run_q <= '0;
    end else if (run_q != RUN_W'(DEGLITCH)) begin
      run_q <= run_q + RUN_W'(1);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_answer_one_cycle: assert property (req.rd_req || req.wr_req |=> rsp.valid)
    else $error("no answer after request");
  a_no_stray_answer: assert property (!(req.rd_req || req.wr_req) |=> !rsp.valid)
    else $error("answer without request");
  a_write_refused: assert property (req.wr_req |=> rsp.write_refused && rsp.data == 8'h00)
    else $error("write not refused");
  a_read_first_reg: assert property (req.rd_req && !req.wr_req && req.addr == 8'h00
    |=> !rsp.unmapped && rsp.data == $past(protection_status))
    else $error("read of first register wrong");
  a_read_second_reg: assert property (req.rd_req && !req.wr_req && req.addr == 8'h01
    |=> !rsp.unmapped && rsp.data == $past(tone_current_status))
    else $error("read of second register wrong");
  a_reserved_zero: assert property ((protection_status & 8'h2a) == 8'h00
    && (tone_current_status & 8'hea) == 8'h00)
    else $error("reserved bit set");
  a_overtemp_set: assert property (junction_temp_c > 8'h96 |-> ##2 protection_status[6])
    else $error("overtemperature flag not set");
  a_overtemp_clear: assert property (junction_temp_c < 8'h87 |-> ##2 !protection_status[6])
    else $error("overtemperature flag not cleared");
  a_supply_flags: assert property (1'b1 |=> protection_status[7] == $past(cond.low_power_diagnostic)
    && protection_status[0] == $past(cond.overload))
    else $error("supply or overload flag wrong");
  a_tone_flags: assert property (1'b1 |=> tone_current_status[0] == $past(cond.tone_detector_input)
    && tone_current_status[2] == ($past(cond.tone_detector_input) && $past(cond.tone_out_of_limits))
    && tone_current_status[4] == $past(cond.load_current_low))
    else $error("tone or current flag wrong");
  a_pulldown_clear: assert property (!cond.pulldown_overcurrent |-> ##2 !protection_status[4])
    else $error("pull-down flag without overcurrent");
  a_pulldown_set: assert property (cond.pulldown_overcurrent && run_q == RUN_W'(DEGLITCH)
    |-> ##2 protection_status[4])
    else $error("pull-down flag not set after persistence");
  a_pulldown_glitch: assert property (cond.pulldown_overcurrent && run_q != RUN_W'(DEGLITCH)
    |-> ##2 !protection_status[4])
    else $error("pull-down flag set before persistence");
endmodule : supply_diag_status_regs_assertions
bind supply_diag_status_regs supply_diag_status_regs_assertions #(.DEGLITCH(DEGLITCH)) chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .cond(cond), .junction_temp_c(junction_temp_c),
  .req(req), .rsp(rsp), .protection_status(protection_status),
  .tone_current_status(tone_current_status));

/* File: supply_diag_status_regs_test.sv */
// self-checking bench for the status bank
// host_ctrl issues requests; a monitor compares answers with queued notes
`timescale 1ns/1ps
module supply_diag_status_regs_test;
  import supply_diag_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  diag_cond_type cond = '0;
  logic [7:0] temp = 8'h00;
  reg_req_type req;
  reg_rsp_type rsp;
  reg_rsp_type exp_q[$];
  int bad_count = 0;
  int tests_run = 0;
  int seed = 32'hc94cf418;
  logic ot = 1'b0;
  always #2 clk_sys = ~clk_sys;
  supply_diag_status_regs #(.DEGLITCH(4)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cond(cond), .junction_temp_c(temp), .req(req), .rsp(rsp),
    .protection_status(), .tone_current_status());
  host_ctrl host (.clk_sys(clk_sys), .req(req));
  task automatic check(input string nm, input reg_rsp_type seen, input reg_rsp_type exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic rd(input logic wr, input logic [7:0] a, input logic [7:0] d);
    exp_q.push_back('{valid: 1'b1, write_refused: wr, unmapped: !wr && a > 8'h01,
      data: wr ? 8'h00 : d});
    host.access(wr, a);
  endtask : rd
  // answer monitor
  always @(posedge clk_sys) begin
    if (rsp.valid === 1'b1) begin
      check("rsp", rsp, exp_q.size() > 0 ? exp_q.pop_front() : reg_rsp_type'(0));
    end
  end
  initial begin
    #20000;
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(1'b0, 8'h00, STATUS_RESET);
    rd(1'b0, 8'h01, STATUS_RESET);
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_sys);
      cond <= diag_cond_type'(7'($random(seed)));
      temp <= 8'h78 + 8'($random(seed) & 8'h3f);
      repeat (10) @(posedge clk_sys);
      if (temp > OVERTEMP_SET_C) ot = 1'b1;
      else if (temp < OVERTEMP_CLEAR_C) ot = 1'b0;
      rd(1'b0, 8'h00, {cond.low_power_diagnostic, ot, 1'b0, cond.pulldown_overcurrent, 1'b0,
        cond.output_voltage_low, 1'b0, cond.overload});
      rd(1'b0, 8'h01, {3'h0, cond.load_current_low, 1'b0, cond.tone_detector_input
        & cond.tone_out_of_limits, 1'b0, cond.tone_detector_input});
      rd(1'b0, 8'(i + 2), 8'h00);
      rd(1'b1, 8'(i % 2), 8'h00);
    end
    repeat (4) @(posedge clk_sys);
    if (exp_q.size() != 0) bad_count++;
    end_sim();
  end
endmodule : supply_diag_status_regs_test
